// ===== svdm_engine.sv
// Structured VDM policy-engine sequencer for UFP answers and DFP discovery.
`timescale 1ns/10ps
`default_nettype none
`include "svdm_map.svh"
module svdm_engine #(
  parameter int unsigned RESP_CYCLES = `SVDM_RESP_CYCLES
) (
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        reset,
  // Port role and ready indication.
  input  wire logic        isUfp,
  input  wire logic        inSrcReady,
  input  wire logic        inSnkReady,
  // Received messages from the protocol layer.
  input  wire logic        rxValid,
  input  wire logic        rxIsReq,
  input  wire logic [2:0]  rxCmd,
  input  wire logic [1:0]  rxType,
  // Transmit request to the protocol layer.
  output logic             txValid,
  output logic [2:0]       txCmd,
  output logic [1:0]       txType,
  input  wire logic        txDone,
  // Device policy manager side.
  input  wire logic        dpmAttnReq,
  input  wire logic        dpmIdentReq,
  input  wire logic        dpmSvidsReq,
  output logic             dpmReq,
  output logic [2:0]       dpmCmd,
  input  wire logic        dpmDataReady,
  input  wire logic        dpmModeEntered,
  input  wire logic        dpmModeRefused,
  output logic             dpmInform,
  output logic [1:0]       dpmResult,
  input  wire logic        dpmAck,
  // Status.
  output logic             engineBusy,
  output logic             returnToSrc,
  output logic             timerRunning
);
  svdm_pkg::svdm_regs_t r_q;
  svdm_pkg::svdm_regs_t r_d;
  logic ready;
  logic respIn;
  logic idleTake;

  assign ready  = inSrcReady | inSnkReady;
  assign respIn = rxValid & ~rxIsReq & (rxCmd == r_q.cmd);
  assign idleTake = (r_q.state == svdm_pkg::ST_READY) & ready;

  always_comb begin
    r_d = r_q;
    if (r_q.timer != 32'h0) begin
      r_d.timer = r_q.timer - 32'h1;
    end
    unique case (r_q.state)
      svdm_pkg::ST_READY: begin
        r_d.busy = 1'b0;
        if (ready) begin
          r_d.srcRole = inSrcReady; // [RULE20]
          if (isUfp && rxValid && rxIsReq) begin
            r_d.cmd = rxCmd;
            r_d.busy = 1'b1;
            if (rxCmd == `SVDM_CMD_IDENT || rxCmd == `SVDM_CMD_SVIDS ||
                rxCmd == `SVDM_CMD_MODES) begin
              r_d.state = svdm_pkg::ST_UFP_GET; // [RULE1] [RULE3] [RULE5]
              r_d.dpmReq = 1'b1;
            end else if (rxCmd == `SVDM_CMD_ENTER) begin
              r_d.state = svdm_pkg::ST_UFP_EVAL; // [RULE7]
              r_d.dpmReq = 1'b1;
            end else if (rxCmd == `SVDM_CMD_EXIT) begin
              r_d.state = svdm_pkg::ST_UFP_EXIT; // [RULE10]
              r_d.dpmReq = 1'b1;
            end else begin
              r_d.busy = 1'b0;
            end
          end else if (isUfp && dpmAttnReq) begin
            r_d.cmd = `SVDM_CMD_ATTN;
            r_d.busy = 1'b1;
            r_d.state = svdm_pkg::ST_UFP_ATTN; // [RULE12]
            r_d.txValid = 1'b1;
            r_d.txCmd = `SVDM_CMD_ATTN;
            r_d.txType = `SVDM_RES_ACK;
          end else if (!isUfp && (dpmIdentReq || dpmSvidsReq)) begin
            r_d.cmd = dpmIdentReq ? `SVDM_CMD_IDENT : `SVDM_CMD_SVIDS;
            r_d.busy = 1'b1;
            r_d.state = svdm_pkg::ST_DFP_REQ; // [RULE13] [RULE16]
            r_d.txValid = 1'b1;
            r_d.txCmd = dpmIdentReq ? `SVDM_CMD_IDENT : `SVDM_CMD_SVIDS;
            r_d.txType = `SVDM_RES_ACK;
          end
        end
      end
      svdm_pkg::ST_UFP_GET: begin
        if (dpmDataReady) begin
          r_d.dpmReq = 1'b0;
          r_d.state = svdm_pkg::ST_UFP_SEND; // [RULE2] [RULE4] [RULE6]
          r_d.txValid = 1'b1;
          r_d.txCmd = r_q.cmd;
          r_d.txType = `SVDM_RES_ACK;
        end
      end
      svdm_pkg::ST_UFP_EVAL: begin
        if (dpmModeEntered) begin
          r_d.dpmReq = 1'b0;
          r_d.state = svdm_pkg::ST_UFP_EACK; // [RULE8]
          r_d.txValid = 1'b1;
          r_d.txCmd = `SVDM_CMD_ENTER;
          r_d.txType = `SVDM_RES_ACK;
        end else if (dpmModeRefused) begin
          r_d.dpmReq = 1'b0;
          r_d.state = svdm_pkg::ST_UFP_ENAK; // [RULE9]
          r_d.txValid = 1'b1;
          r_d.txCmd = `SVDM_CMD_ENTER;
          r_d.txType = `SVDM_RES_NAK;
        end
      end
      svdm_pkg::ST_UFP_EXIT: begin
        if (dpmDataReady) begin
          r_d.dpmReq = 1'b0;
          r_d.state = svdm_pkg::ST_UFP_XACK; // [RULE11]
          r_d.txValid = 1'b1;
          r_d.txCmd = `SVDM_CMD_EXIT;
          r_d.txType = `SVDM_RES_ACK;
        end
      end
      svdm_pkg::ST_UFP_SEND, svdm_pkg::ST_UFP_EACK, svdm_pkg::ST_UFP_ENAK,
      svdm_pkg::ST_UFP_XACK, svdm_pkg::ST_UFP_ATTN: begin
        if (txDone) begin
          r_d.txValid = 1'b0;
          r_d.busy = 1'b0;
          r_d.state = svdm_pkg::ST_READY; // [RULE2] [RULE12] [RULE20]
        end
      end
      svdm_pkg::ST_DFP_REQ: begin
        if (txDone) begin
          r_d.txValid = 1'b0;
          r_d.timer = RESP_CYCLES; // [RULE13] [RULE16]
          r_d.state = svdm_pkg::ST_DFP_WAIT;
        end
      end
      svdm_pkg::ST_DFP_WAIT: begin
        if (respIn) begin
          r_d.timer = 32'h0; // [RULE21]
          r_d.result = rxType;
          r_d.dpmInform = 1'b1;
          if (rxType == `SVDM_RES_ACK) begin
            r_d.state = svdm_pkg::ST_DFP_ACKED; // [RULE14] [RULE17]
          end else begin
            r_d.state = svdm_pkg::ST_DFP_NAKED; // [RULE15] [RULE18]
          end
        end else if (r_q.timer == 32'h1) begin
          r_d.result = `SVDM_RES_TMO; // [RULE15] [RULE18]
          r_d.dpmInform = 1'b1;
          r_d.state = svdm_pkg::ST_DFP_NAKED;
        end
      end
      svdm_pkg::ST_DFP_ACKED, svdm_pkg::ST_DFP_NAKED: begin
        if (dpmAck) begin
          r_d.dpmInform = 1'b0;
          r_d.busy = 1'b0;
          r_d.state = svdm_pkg::ST_READY; // [RULE19] [RULE20]
        end
      end
      default: begin
        r_d.state = svdm_pkg::ST_READY;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      r_q <= '{state: svdm_pkg::ST_READY, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  assign txValid      = r_q.txValid;
  assign txCmd        = r_q.txCmd;
  assign txType       = r_q.txType;
  assign dpmReq       = r_q.dpmReq;
  assign dpmCmd       = r_q.cmd;
  assign dpmInform    = r_q.dpmInform;
  assign dpmResult    = r_q.result;
  assign engineBusy   = r_q.busy;
  assign returnToSrc  = r_q.srcRole;
  assign timerRunning = (r_q.timer != 32'h0);

  property p_ufp_get;
    @(posedge mclk) disable iff (reset)
      (r_q.state == svdm_pkg::ST_READY && ready && isUfp && rxValid && rxIsReq &&
       rxCmd == `SVDM_CMD_IDENT) |=> (dpmReq && r_q.state == svdm_pkg::ST_UFP_GET);
  endproperty
  a_ufp_get: assert property (p_ufp_get) else $error("identity request not forwarded"); // [RULE1]

  property p_ufp_ack;
    @(posedge mclk) disable iff (reset)
      (r_q.state == svdm_pkg::ST_UFP_GET && dpmDataReady)
        |=> (txValid && txType == `SVDM_RES_ACK && txCmd == $past(r_q.cmd));
  endproperty
  a_ufp_ack: assert property (p_ufp_ack) else $error("discover ACK not sent"); // [RULE2]

  property p_enter_nak;
    @(posedge mclk) disable iff (reset)
      (r_q.state == svdm_pkg::ST_UFP_EVAL && !dpmModeEntered && dpmModeRefused)
        |=> (txValid && txType == `SVDM_RES_NAK && txCmd == `SVDM_CMD_ENTER);
  endproperty
  a_enter_nak: assert property (p_enter_nak) else $error("enter NAK not sent"); // [RULE9]

  property p_enter_ack;
    @(posedge mclk) disable iff (reset)
      (r_q.state == svdm_pkg::ST_UFP_EVAL && dpmModeEntered)
        |=> (txValid && txType == `SVDM_RES_ACK && txCmd == `SVDM_CMD_ENTER);
  endproperty
  a_enter_ack: assert property (p_enter_ack) else $error("enter ACK not sent"); // [RULE8]

  property p_tx_ret;
    @(posedge mclk) disable iff (reset)
      (txValid && txDone && r_q.state != svdm_pkg::ST_DFP_REQ)
        |=> (r_q.state == svdm_pkg::ST_READY && !txValid);
  endproperty
  a_tx_ret: assert property (p_tx_ret) else $error("no return to ready"); // [RULE11]

  property p_timer_start;
    @(posedge mclk) disable iff (reset)
      (r_q.state == svdm_pkg::ST_DFP_REQ && txDone) |=> (r_q.timer == RESP_CYCLES);
  endproperty
  a_timer_start: assert property (p_timer_start) else $error("timer not started"); // [RULE13]

  property p_cancel;
    @(posedge mclk) disable iff (reset)
      (r_q.state == svdm_pkg::ST_DFP_WAIT && respIn) |=> (!timerRunning && dpmInform);
  endproperty
  a_cancel: assert property (p_cancel) else $error("timer not cancelled"); // [RULE21]

  property p_timeout;
    @(posedge mclk) disable iff (reset)
      (r_q.state == svdm_pkg::ST_DFP_WAIT && !respIn && r_q.timer == 32'h1)
        |=> (r_q.state == svdm_pkg::ST_DFP_NAKED && dpmResult == `SVDM_RES_TMO);
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not reported"); // [RULE18]

  property p_inform_ret;
    @(posedge mclk) disable iff (reset)
      (dpmInform && dpmAck) |=> (r_q.state == svdm_pkg::ST_READY && !dpmInform);
  endproperty
  a_inform_ret: assert property (p_inform_ret) else $error("no ready after inform"); // [RULE19]

  property p_single;
    @(posedge mclk) disable iff (reset)
      (r_q.state != svdm_pkg::ST_READY) |-> engineBusy;
  endproperty
  a_single: assert property (p_single) else $error("busy not shown"); // [RULE20]

  property p_ufp_svids;
    @(posedge mclk) disable iff (reset)
      (idleTake && isUfp && rxValid && rxIsReq && rxCmd == `SVDM_CMD_SVIDS)
        |=> (dpmReq && dpmCmd == `SVDM_CMD_SVIDS && r_q.state == svdm_pkg::ST_UFP_GET);
  endproperty
  a_ufp_svids: assert property (p_ufp_svids) else $error("SVID request not forwarded"); // [RULE3]

  property p_ufp_modes;
    @(posedge mclk) disable iff (reset)
      (idleTake && isUfp && rxValid && rxIsReq && rxCmd == `SVDM_CMD_MODES)
        |=> (dpmReq && dpmCmd == `SVDM_CMD_MODES && r_q.state == svdm_pkg::ST_UFP_GET);
  endproperty
  a_ufp_modes: assert property (p_ufp_modes) else $error("mode request not forwarded"); // [RULE5]

  property p_ufp_eval;
    @(posedge mclk) disable iff (reset)
      (idleTake && isUfp && rxValid && rxIsReq && rxCmd == `SVDM_CMD_ENTER)
        |=> (dpmReq && dpmCmd == `SVDM_CMD_ENTER && r_q.state == svdm_pkg::ST_UFP_EVAL);
  endproperty
  a_ufp_eval: assert property (p_ufp_eval) else $error("enter request not judged"); // [RULE7]

  property p_ufp_exit;
    @(posedge mclk) disable iff (reset)
      (idleTake && isUfp && rxValid && rxIsReq && rxCmd == `SVDM_CMD_EXIT)
        |=> (dpmReq && dpmCmd == `SVDM_CMD_EXIT && r_q.state == svdm_pkg::ST_UFP_EXIT);
  endproperty
  a_ufp_exit: assert property (p_ufp_exit) else $error("exit request not forwarded"); // [RULE10]

  property p_exit_ack;
    @(posedge mclk) disable iff (reset)
      (r_q.state == svdm_pkg::ST_UFP_EXIT && dpmDataReady)
        |=> (txValid && txType == `SVDM_RES_ACK && txCmd == `SVDM_CMD_EXIT);
  endproperty
  a_exit_ack: assert property (p_exit_ack) else $error("exit ACK not sent"); // [RULE11]

  property p_attn;
    @(posedge mclk) disable iff (reset)
      (idleTake && isUfp && !(rxValid && rxIsReq) && dpmAttnReq)
        |=> (txValid && txCmd == `SVDM_CMD_ATTN && r_q.state == svdm_pkg::ST_UFP_ATTN);
  endproperty
  a_attn: assert property (p_attn) else $error("attention not sent"); // [RULE12]

  property p_dfp_ident;
    @(posedge mclk) disable iff (reset)
      (idleTake && !isUfp && dpmIdentReq)
        |=> (txValid && txCmd == `SVDM_CMD_IDENT && r_q.state == svdm_pkg::ST_DFP_REQ);
  endproperty
  a_dfp_ident: assert property (p_dfp_ident) else $error("identity request not sent"); // [RULE13]

  property p_dfp_svids;
    @(posedge mclk) disable iff (reset)
      (idleTake && !isUfp && !dpmIdentReq && dpmSvidsReq)
        |=> (txValid && txCmd == `SVDM_CMD_SVIDS && r_q.state == svdm_pkg::ST_DFP_REQ);
  endproperty
  a_dfp_svids: assert property (p_dfp_svids) else $error("SVID request not sent"); // [RULE16]

  property p_ident_acked;
    @(posedge mclk) disable iff (reset)
      (r_q.state == svdm_pkg::ST_DFP_WAIT && respIn && rxType == `SVDM_RES_ACK &&
       r_q.cmd == `SVDM_CMD_IDENT) |=> (r_q.state == svdm_pkg::ST_DFP_ACKED && dpmInform);
  endproperty
  a_ident_acked: assert property (p_ident_acked) else $error("identity not passed on"); // [RULE14]

  property p_svids_acked;
    @(posedge mclk) disable iff (reset)
      (r_q.state == svdm_pkg::ST_DFP_WAIT && respIn && rxType == `SVDM_RES_ACK &&
       r_q.cmd == `SVDM_CMD_SVIDS) |=> (r_q.state == svdm_pkg::ST_DFP_ACKED && dpmInform);
  endproperty
  a_svids_acked: assert property (p_svids_acked) else $error("SVID ACK not taken"); // [RULE17]

  property p_dfp_refused;
    @(posedge mclk) disable iff (reset)
      (r_q.state == svdm_pkg::ST_DFP_WAIT && respIn && rxType != `SVDM_RES_ACK)
        |=> (r_q.state == svdm_pkg::ST_DFP_NAKED && dpmInform && dpmResult == $past(rxType));
  endproperty
  a_dfp_refused: assert property (p_dfp_refused) else $error("refusal not reported"); // [RULE15]

  property p_tx_hold;
    @(posedge mclk) disable iff (reset) (txValid && !txDone) |=> txValid;
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("transmit request dropped"); // [RULE2]

  property p_inform_hold;
    @(posedge mclk) disable iff (reset) (dpmInform && !dpmAck) |=> dpmInform;
  endproperty
  a_inform_hold: assert property (p_inform_hold) else $error("result dropped early"); // [RULE19]

  property p_role_kept;
    @(posedge mclk) disable iff (reset) (r_q.state != svdm_pkg::ST_READY) |=> $stable(returnToSrc);
  endproperty
  a_role_kept: assert property (p_role_kept) else $error("ready role changed"); // [RULE20]

  property p_timer_idle;
    @(posedge mclk) disable iff (reset) (r_q.state != svdm_pkg::ST_DFP_WAIT) |-> !timerRunning;
  endproperty
  a_timer_idle: assert property (p_timer_idle) else $error("timer left running"); // [RULE21]

  c_ident: cover property (@(posedge mclk) disable iff (reset)
    r_q.state == svdm_pkg::ST_UFP_SEND && txDone);
  c_nak: cover property (@(posedge mclk) disable iff (reset)
    r_q.state == svdm_pkg::ST_UFP_ENAK);
  c_dfp_ack: cover property (@(posedge mclk) disable iff (reset)
    r_q.state == svdm_pkg::ST_DFP_ACKED);
  c_tmo: cover property (@(posedge mclk) disable iff (reset)
    r_q.state == svdm_pkg::ST_DFP_NAKED && dpmResult == `SVDM_RES_TMO);
endmodule : svdm_engine
`default_nettype wire

// ===== svdm_map.svh
// Constants and the contract list of the structured VDM policy engine.
// Contract
// RULE1: UFP in Ready, Discover Identity request arrives: enter get-identity, ask manager for identity.
// RULE2: Identity data supplied: send Discover Identity ACK, then return to Ready.
// RULE3: UFP in Ready, Discover SVIDs request arrives: ask manager for SVID list.
// RULE4: SVID data supplied: send Discover SVIDs ACK, then return to Ready.
// RULE5: UFP in Ready, Discover Modes request arrives: ask manager for mode information.
// RULE6: Mode data supplied: send Discover Modes ACK, then return to Ready.
// RULE7: UFP in Ready, Enter Mode request: manager judges it and enters mode if acceptable.
// RULE8: Manager reports mode active: send Enter Mode ACK, then return to Ready.
// RULE9: Manager refuses entry: send Enter Mode NAK with manager content, then Ready.
// RULE10: UFP in Ready, Exit Mode request: direct manager to leave the named mode.
// RULE11: Mode left: send Exit Mode ACK, then return to Ready.
// RULE12: Manager wants attention: send Attention request, then return to Ready.
// RULE13: DFP in Ready, manager asks identity discovery: send request, start response timer.
// RULE14: Identity ACK received: pass identity data to manager, then return to Ready.
// RULE15: Identity NAK, BUSY or timeout: report which outcome to manager, then Ready.
// RULE16: DFP in Ready, manager asks SVID discovery: send request, start response timer.
// RULE17: SVIDs ACK received while waiting: advance to SVIDs-acknowledged state.
// RULE18: SVIDs NAK, BUSY or timeout while waiting: go to SVIDs-refused state.
// RULE19: Acknowledged hands SVID data to manager; refused reports outcome; then Ready.
// RULE20: Return to the Ready state entered from; one exchange active at a time.
// RULE21: Cancel response timer on any ACK, NAK or BUSY to the outstanding request.
// RULE22: Partner answers each Discover request before the response timer expires.
`ifndef SVDM_MAP_SVH
`define SVDM_MAP_SVH
`define SVDM_RESP_TIME_MS   27
`define SVDM_CLK_HZ         25000000
`define SVDM_RESP_CYCLES    ((`SVDM_RESP_TIME_MS * `SVDM_CLK_HZ) / 1000)
`define SVDM_CMD_W          3
`define SVDM_CMD_IDENT      3'h1
`define SVDM_CMD_SVIDS      3'h2
`define SVDM_CMD_MODES      3'h3
`define SVDM_CMD_ENTER      3'h4
`define SVDM_CMD_EXIT       3'h5
`define SVDM_CMD_ATTN       3'h6
`define SVDM_RES_W          2
`define SVDM_RES_ACK        2'h0
`define SVDM_RES_NAK        2'h1
`define SVDM_RES_BUSY       2'h2
`define SVDM_RES_TMO        2'h3
`endif

// ===== svdm_partner_model.sv
// Protocol layer and port partner model facing the structured VDM engine.
`timescale 1ns/10ps
`default_nettype none
module svdm_partner_model #(
  parameter int DELAY = 3
) (
  // Clock.
  input  wire logic       mclk,
  // Transmit side of the engine.
  input  wire logic       txValid,
  input  wire logic [2:0] txCmd,
  input  wire logic [1:0] txType,
  output logic            txDone,
  // Messages towards the engine.
  output logic            rxValid,
  output logic            rxIsReq,
  output logic [2:0]      rxCmd,
  output logic [1:0]      rxType,
  // Answer control; a type of 3 keeps the partner silent.
  input  wire logic       respEn,
  input  wire logic [1:0] respType
);
  logic [2:0] sentCmd;

  task automatic sendMsg(input logic isReq, input logic [2:0] cmd, input logic [1:0] typ);
    rxValid = 1'h1;
    rxIsReq = isReq;
    rxCmd   = cmd;
    rxType  = typ;
    @(negedge mclk);
    // Idle lines show the inverse so a stale message is never mistaken for a new one.
    rxValid = 1'h0;
    rxIsReq = ~isReq;
    rxCmd   = ~cmd;
    rxType  = ~typ;
  endtask : sendMsg

  initial begin
    txDone  = 1'h0;
    rxValid = 1'h0;
    rxIsReq = 1'h0;
    rxCmd   = 3'h0;
    rxType  = 2'h0;
    forever begin
      @(negedge mclk);
      if (txValid === 1'h1) begin
        repeat (DELAY) @(negedge mclk);
        sentCmd = txCmd;
        txDone  = 1'h1;
        @(negedge mclk);
        txDone = 1'h0;
        if (respEn === 1'h1 && respType !== 2'h3) begin
          repeat (DELAY) @(negedge mclk);
          sendMsg(1'h0, sentCmd, respType);
        end
      end
    end
  end
endmodule : svdm_partner_model
`default_nettype wire

// ===== svdm_pkg.sv
// Types of the structured VDM policy engine.
package svdm_pkg;
  typedef enum logic [12:0] {
    ST_READY     = 13'h0001,
    ST_UFP_GET   = 13'h0002,
    ST_UFP_SEND  = 13'h0004,
    ST_UFP_EVAL  = 13'h0008,
    ST_UFP_EACK  = 13'h0010,
    ST_UFP_ENAK  = 13'h0020,
    ST_UFP_EXIT  = 13'h0040,
    ST_UFP_XACK  = 13'h0080,
    ST_UFP_ATTN  = 13'h0100,
    ST_DFP_REQ   = 13'h0200,
    ST_DFP_WAIT  = 13'h0400,
    ST_DFP_ACKED = 13'h0800,
    ST_DFP_NAKED = 13'h1000
  } svdm_state_t;
  typedef struct packed {
    svdm_state_t state;
    logic        srcRole;
    logic [2:0]  cmd;
    logic [31:0] timer;
    logic [1:0]  result;
    logic        txValid;
    logic [2:0]  txCmd;
    logic [1:0]  txType;
    logic        dpmReq;
    logic        dpmInform;
    logic        busy;
  } svdm_regs_t;
endpackage : svdm_pkg

// ===== testbench.sv
// Self-checking testbench of the structured VDM policy engine.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int RESP = 50;
  logic       mclk, reset, isUfp, inSrcReady, inSnkReady;
  logic       rxValid, rxIsReq, txValid, txDone, dpmReq, dpmInform;
  logic [2:0] rxCmd, txCmd, dpmCmd;
  logic [1:0] rxType, txType, dpmResult, respType;
  logic       dpmAttnReq, dpmIdentReq, dpmSvidsReq, dpmDataReady, dpmModeEntered;
  logic       dpmModeRefused, dpmAck, engineBusy, returnToSrc, timerRunning, respEn;
  int         mismatches, n_checks;

  svdm_engine #(.RESP_CYCLES(RESP)) svdm_engine_i (
    .mclk(mclk), .reset(reset), .isUfp(isUfp), .inSrcReady(inSrcReady),
    .inSnkReady(inSnkReady), .rxValid(rxValid), .rxIsReq(rxIsReq), .rxCmd(rxCmd),
    .rxType(rxType), .txValid(txValid), .txCmd(txCmd), .txType(txType), .txDone(txDone),
    .dpmAttnReq(dpmAttnReq), .dpmIdentReq(dpmIdentReq), .dpmSvidsReq(dpmSvidsReq),
    .dpmReq(dpmReq), .dpmCmd(dpmCmd), .dpmDataReady(dpmDataReady),
    .dpmModeEntered(dpmModeEntered), .dpmModeRefused(dpmModeRefused),
    .dpmInform(dpmInform), .dpmResult(dpmResult), .dpmAck(dpmAck),
    .engineBusy(engineBusy), .returnToSrc(returnToSrc), .timerRunning(timerRunning));

  svdm_partner_model svdm_partner_model_i (
    .mclk(mclk), .txValid(txValid), .txCmd(txCmd), .txType(txType), .txDone(txDone),
    .rxValid(rxValid), .rxIsReq(rxIsReq), .rxCmd(rxCmd), .rxType(rxType),
    .respEn(respEn), .respType(respType));

  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic sel(input int k);
    case (k)
      0: sel = dpmReq;
      1: sel = txValid;
      2: sel = dpmInform;
      default: sel = timerRunning;
    endcase
  endfunction : sel

  // Waits a bounded time for a watched output to reach a level, then compares it.
  task automatic waitFor(input int k, input logic v, output int n);
    n = 0;
    while (sel(k) !== v && n < 200) begin
      @(negedge mclk);
      n++;
    end
    check(32'(sel(k)), 32'(v));
  endtask : waitFor

  // Pulses one manager input for a cycle: 0 data, 1 entered, 2 refused, 3 informed.
  task automatic pulse(input int k);
    {dpmAck, dpmModeRefused, dpmModeEntered, dpmDataReady} = 4'h1 << k;
    @(negedge mclk);
    {dpmAck, dpmModeRefused, dpmModeEntered, dpmDataReady} = 4'h0;
  endtask : pulse

  task automatic ufp_xchg(input logic [2:0] cmd, input logic src, input int verdict);
    int n;
    isUfp = 1'h1;
    inSrcReady = src;
    inSnkReady = ~src;
    svdm_partner_model_i.sendMsg(1'h1, cmd, 2'h0);
    waitFor(0, 1'h1, n);
    check(32'(dpmCmd), 32'(cmd));
    check(32'(returnToSrc), 32'(src));
    pulse(verdict);
    waitFor(1, 1'h1, n);
    check(32'({dpmReq, txCmd, txType}), {27'h0, cmd, 1'h0, verdict == 2});
    waitFor(1, 1'h0, n);
    check(32'(engineBusy), 32'h0);
  endtask : ufp_xchg

  task automatic ufp_attn_and_unknown();
    int n;
    isUfp = 1'h1;
    svdm_partner_model_i.sendMsg(1'h1, 3'h7, 2'h0);
    repeat (3) @(negedge mclk);
    check(32'({engineBusy, dpmReq, txValid}), 32'h0);
    dpmAttnReq = 1'h1;
    waitFor(1, 1'h1, n);
    dpmAttnReq = 1'h0;
    check(32'({txCmd, txType}), 32'h18);
    waitFor(1, 1'h0, n);
    check(32'(engineBusy), 32'h0);
  endtask : ufp_attn_and_unknown

  task automatic dfp_disc(input logic [2:0] cmd, input logic [1:0] rt);
    int n;
    isUfp = 1'h0;
    respType = rt;
    respEn = 1'h1;
    dpmIdentReq = (cmd == 3'h1);
    dpmSvidsReq = (cmd == 3'h2);
    waitFor(1, 1'h1, n);
    dpmIdentReq = 1'h0;
    dpmSvidsReq = 1'h0;
    check(32'({txCmd, txType}), {27'h0, cmd, 2'h0});
    waitFor(3, 1'h1, n);
    waitFor(2, 1'h1, n);
    check(32'(dpmResult), 32'(rt));
    check(32'(timerRunning), 32'h0);
    if (rt == 2'h3) check(32'(n >= RESP - 3 && n <= RESP + 3), 32'h1);
    pulse(3);
    waitFor(2, 1'h0, n);
    check(32'(engineBusy), 32'h0);
    respEn = 1'h0;
    @(negedge mclk);
  endtask : dfp_disc

  // Cuts a discovery off by reset while the response timer runs, then starts afresh.
  task automatic reset_mid_run();
    int n;
    respType = 2'h3;
    dpmIdentReq = 1'h1;
    waitFor(1, 1'h1, n);
    dpmIdentReq = 1'h0;
    waitFor(3, 1'h1, n);
    svdm_partner_model_i.sendMsg(1'h0, 3'h2, 2'h0);
    check(32'({dpmInform, timerRunning}), 32'h1);
    reset = 1'h1;
    @(negedge mclk);
    check(32'({txValid, dpmReq, dpmInform, engineBusy, timerRunning}), 32'h0);
    reset = 1'h0;
    dfp_disc(3'h2, 2'h0);
  endtask : reset_mid_run

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  initial begin
    #400000;
    mismatches++;
    give_verdict();
  end

  initial begin
    {reset, isUfp, inSrcReady, inSnkReady, dpmAttnReq, dpmIdentReq, dpmSvidsReq} = 7'h48;
    {dpmAck, dpmModeRefused, dpmModeEntered, dpmDataReady, respEn, respType} = 7'h0;
    mismatches = 0;
    n_checks = 0;
    repeat (10) @(negedge mclk);
    check(32'({txValid, dpmReq, dpmInform, engineBusy}), 32'h0);
    reset = 1'h0;
    for (int c = 1; c <= 5; c++) if (c != 4) ufp_xchg(3'(c), c[0], 0);
    ufp_xchg(3'h4, 1'h1, 1);
    ufp_xchg(3'h4, 1'h0, 2);
    ufp_attn_and_unknown();
    for (int t = 0; t < 4; t++) begin
      dfp_disc(3'h1, 2'(t));
      dfp_disc(3'h2, 2'(t));
    end
    reset_mid_run();
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
